// ### logic/sewr_pkg.sv
package sewr_pkg;
    // word layout of the attached memory
    localparam int ADDR_W = 8;
    localparam int WORD_W = 16;
    // serial frame: start bit, op code, address, then dummy plus data
    localparam logic START_BIT = 1'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic DUMMY_BITS = 1'h1;
    localparam int OUT_BITS = 1 + 2 + ADDR_W;
    localparam int IN_BITS = 1 + WORD_W;
    localparam logic [4:0] OUT_LAST = 5'(OUT_BITS - 1);
    localparam logic [4:0] IN_LAST = 5'(IN_BITS - 1);
    // one shift-clock period spans this many link-clock cycles
    localparam int SLOT_PHASES = 8;
    localparam logic [2:0] PH_SAMPLE = 3'h3;
    localparam logic [2:0] PH_LAST = 3'(SLOT_PHASES - 1);
    // reset values of the pins, and the fixed level driven on the strap pin
    localparam logic SCLK_RST = 1'h0;
    localparam logic SELECT_RST = 1'h0;
    localparam logic OE_N_RST = 1'h1;
    localparam logic WIDE_ORG = 1'h1;
    // buffer size
    localparam int BUF_DEPTH = 2;

    typedef enum logic [4:0] {
        SEWR_IDLE = 5'h01,
        SEWR_SELECT = 5'h02,
        SEWR_SEND = 5'h04,
        SEWR_RECV = 5'h08,
        SEWR_FINISH = 5'h10
    } sewr_state_e;
endpackage

// ### logic/sewr_top.sv
// How it works
// - memory is treated as 16-bit words, one address per word, wide strap assumed.
// - only read frames are ever built; no other instruction exists here.
// - the op code sent after the start bit is binary 10.
// - an eight-bit word address follows the op code directly.
// - frame is start bit, 2-bit op code, 8-bit address, one dummy bit, 16-bit data.
// - every word gets its own full frame; sequential output is not used.
// - chip select rises a whole shift-clock period before the start bit.
// - op code bits change on falling edges of the shift clock.
// - each address bit changes on a falling edge of the shift clock.
// - returned bits are sampled just before rising edges; dummy is discarded.
// - fetched words feed resource description and power-up defaults.
`timescale 1ns/1ns
module sewr_top
    import sewr_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH,
    parameter int WIDTH = WORD_W
)
(
    // system side
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // word requests
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [ADDR_W-1:0] req_addr,
    // fetched words, for resource data and power-up defaults
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data,
    // link side
    input wire logic link_clk,
    output logic memory_select_out,
    output logic shift_clk_out,
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe_n,
    output logic word_size_strap
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    // ---------------- system clock domain ----------------
    logic busy_reg, busy_next;
    logic req_tgl_reg, req_tgl_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic dn_ack_reg, dn_ack_next;
    logic dn_s1_reg, dn_s2_reg, dn_s3_reg;
    logic [WIDTH-1:0] buf_mem [DEPTH];
    logic [WIDTH-1:0] buf_mem_next [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [CNT_W-1:0] count_reg, count_next;
    logic [WIDTH-1:0] link_word_reg;
    logic link_done_tgl_reg;
    logic push, pop;

    // one word in flight at a time, and only when its slot is free, so a stall never loses a word
    assign req_ready = ce && !busy_reg && (count_reg < CNT_W'(DEPTH));
    assign rd_valid = (count_reg != '0);
    assign rd_data = buf_mem[rd_ptr_reg];
    assign word_size_strap = WIDE_ORG;

    always_comb
    begin
        busy_next = busy_reg;
        req_tgl_next = req_tgl_reg;
        addr_next = addr_reg;
        dn_ack_next = dn_ack_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        buf_mem_next = buf_mem;
        push = 1'h0;
        pop = 1'h0;
        if (ce)
        begin
            if (req_valid && req_ready)
            begin
                busy_next = 1'h1;
                addr_next = req_addr;
                req_tgl_next = ~req_tgl_reg;
            end
            // the word is held still by the link until the next request, so it is safe to copy here
            if (dn_s2_reg == dn_s3_reg && dn_s3_reg != dn_ack_reg)
            begin
                dn_ack_next = dn_s3_reg;
                busy_next = 1'h0;
                push = 1'h1;
                buf_mem_next[wr_ptr_reg] = link_word_reg;
                wr_ptr_next = (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(wr_ptr_reg + 1'h1);
            end
            if (rd_valid && rd_ready)
            begin
                pop = 1'h1;
                rd_ptr_next = (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(rd_ptr_reg + 1'h1);
            end
            if (push && !pop)
                count_next = CNT_W'(count_reg + 1'h1);
            else if (pop && !push)
                count_next = CNT_W'(count_reg - 1'h1);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            busy_reg <= 1'h0;
            req_tgl_reg <= 1'h0;
            addr_reg <= '0;
            dn_ack_reg <= 1'h0;
            dn_s1_reg <= 1'h0;
            dn_s2_reg <= 1'h0;
            dn_s3_reg <= 1'h0;
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            for (int i = 0; i < DEPTH; i++)
                buf_mem[i] <= '0;
        end
        else
        begin
            busy_reg <= busy_next;
            req_tgl_reg <= req_tgl_next;
            addr_reg <= addr_next;
            dn_ack_reg <= dn_ack_next;
            dn_s1_reg <= link_done_tgl_reg;
            dn_s2_reg <= dn_s1_reg;
            dn_s3_reg <= dn_s2_reg;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
            buf_mem <= buf_mem_next;
        end
    end

    // ---------------- link clock domain ----------------
    sewr_state_e state_reg, state_next;
    logic [2:0] phase_reg, phase_next;
    logic [4:0] bit_reg, bit_next;
    logic [OUT_BITS-1:0] out_sr_reg, out_sr_next;
    logic [WIDTH-1:0] in_sr_reg, in_sr_next;
    logic [WIDTH-1:0] link_word_next;
    logic sclk_reg, sclk_next;
    logic cs_reg, cs_next;
    logic sdo_reg, sdo_next;
    logic oe_n_reg, oe_n_next;
    logic link_done_tgl_next;
    logic rq_ack_reg, rq_ack_next;
    logic rq_s1_reg, rq_s2_reg, rq_s3_reg;
    logic ce_s1_reg, ce_s2_reg, ce_s3_reg, ce_val_reg, ce_val_next;
    logic sdi_s1_reg, sdi_s2_reg, sdi_s3_reg;
    logic sdi_val_reg, sdi_val_next;
    logic slot_end;

    assign memory_select_out = cs_reg;
    assign shift_clk_out = sclk_reg;
    assign serial_data_line_out = sdo_reg;
    assign serial_data_line_oe_n = oe_n_reg;
    assign slot_end = (phase_reg == PH_LAST);

    always_comb
    begin
        state_next = state_reg;
        phase_next = phase_reg;
        bit_next = bit_reg;
        out_sr_next = out_sr_reg;
        in_sr_next = in_sr_reg;
        link_word_next = link_word_reg;
        sclk_next = sclk_reg;
        cs_next = cs_reg;
        sdo_next = sdo_reg;
        oe_n_next = oe_n_reg;
        link_done_tgl_next = link_done_tgl_reg;
        rq_ack_next = rq_ack_reg;
        // a pin change counts once two stages agree
        sdi_val_next = (sdi_s2_reg == sdi_s3_reg) ? sdi_s3_reg : sdi_val_reg;
        ce_val_next = (ce_s2_reg == ce_s3_reg) ? ce_s3_reg : ce_val_reg;
        if (ce_val_reg)
        begin
            if (state_reg != SEWR_IDLE)
            begin
                phase_next = PH_LAST == phase_reg ? 3'h0 : 3'(phase_reg + 1'h1);
                // rising edge after the sample phase, falling edge at slot end
                if (phase_reg == PH_SAMPLE && state_reg != SEWR_FINISH)
                    sclk_next = 1'h1;
                if (slot_end)
                    sclk_next = 1'h0;
            end
            unique case (state_reg)
                SEWR_IDLE:
                begin
                    if (rq_s2_reg == rq_s3_reg && rq_s3_reg != rq_ack_reg)
                    begin
                        rq_ack_next = rq_s3_reg;
                        // select first, line held low for one period
                        cs_next = 1'h1;
                        oe_n_next = 1'h0;
                        sdo_next = 1'h0;
                        phase_next = 3'h0;
                        out_sr_next = {START_BIT, OP_READ, addr_reg};
                        state_next = SEWR_SELECT;
                    end
                end
                SEWR_SELECT:
                begin
                    if (slot_end)
                    begin
                        sdo_next = out_sr_reg[OUT_BITS-1];
                        out_sr_next = {out_sr_reg[OUT_BITS-2:0], 1'h0};
                        bit_next = 5'h0;
                        state_next = SEWR_SEND;
                    end
                end
                SEWR_SEND:
                begin
                    if (slot_end)
                    begin
                        if (bit_reg == OUT_LAST)
                        begin
                            oe_n_next = 1'h1;
                            sdo_next = 1'h0;
                            bit_next = 5'h0;
                            state_next = SEWR_RECV;
                        end
                        else
                        begin
                            sdo_next = out_sr_reg[OUT_BITS-1];
                            out_sr_next = {out_sr_reg[OUT_BITS-2:0], 1'h0};
                            bit_next = 5'(bit_reg + 1'h1);
                        end
                    end
                end
                SEWR_RECV:
                begin
                    // sample just before rise, drop dummy
                    if (phase_reg == PH_SAMPLE && bit_reg >= 5'(DUMMY_BITS))
                        in_sr_next = {in_sr_reg[WIDTH-2:0], sdi_val_reg};
                    if (slot_end)
                    begin
                        // frame closes after sixteen data bits
                        if (bit_reg == IN_LAST)
                        begin
                            cs_next = 1'h0;
                            state_next = SEWR_FINISH;
                        end
                        else
                            bit_next = 5'(bit_reg + 1'h1);
                    end
                end
                SEWR_FINISH:
                begin
                    // select stays low one full period before the word is reported
                    if (slot_end)
                    begin
                        link_word_next = in_sr_reg;
                        link_done_tgl_next = ~link_done_tgl_reg;
                        state_next = SEWR_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= SEWR_IDLE;
            phase_reg <= 3'h0;
            bit_reg <= 5'h0;
            out_sr_reg <= '0;
            in_sr_reg <= '0;
            link_word_reg <= '0;
            sclk_reg <= SCLK_RST;
            cs_reg <= SELECT_RST;
            sdo_reg <= 1'h0;
            oe_n_reg <= OE_N_RST;
            link_done_tgl_reg <= 1'h0;
            rq_ack_reg <= 1'h0;
            rq_s1_reg <= 1'h0;
            rq_s2_reg <= 1'h0;
            rq_s3_reg <= 1'h0;
            ce_s1_reg <= 1'h0;
            ce_s2_reg <= 1'h0;
            ce_s3_reg <= 1'h0;
            ce_val_reg <= 1'h0;
            sdi_s1_reg <= 1'h0;
            sdi_s2_reg <= 1'h0;
            sdi_s3_reg <= 1'h0;
            sdi_val_reg <= 1'h0;
        end
        else
        begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            bit_reg <= bit_next;
            out_sr_reg <= out_sr_next;
            in_sr_reg <= in_sr_next;
            link_word_reg <= link_word_next;
            sclk_reg <= sclk_next;
            cs_reg <= cs_next;
            sdo_reg <= sdo_next;
            oe_n_reg <= oe_n_next;
            link_done_tgl_reg <= link_done_tgl_next;
            rq_ack_reg <= rq_ack_next;
            rq_s1_reg <= req_tgl_reg;
            rq_s2_reg <= rq_s1_reg;
            rq_s3_reg <= rq_s2_reg;
            ce_s1_reg <= ce;
            ce_s2_reg <= ce_s1_reg;
            ce_s3_reg <= ce_s2_reg;
            ce_val_reg <= ce_val_next;
            sdi_s1_reg <= serial_data_line_in;
            sdi_s2_reg <= sdi_s1_reg;
            sdi_s3_reg <= sdi_s2_reg;
            sdi_val_reg <= sdi_val_next;
        end
    end
endmodule

// ### test/sewr_mem_model.sv
`timescale 1ns/1ns
module sewr_mem_model
(
    // pins
    input wire logic sel,
    input wire logic sclk,
    input wire logic din,
    input wire logic slow,
    output logic dq,
    // observation
    output logic [7:0] last_addr,
    output int frames,
    output int bad_ops
);
    logic [10:0] sh = 11'h000;
    logic [15:0] w = 16'h0000;
    int n = 0;
    initial dq = 1'h0;
    initial frames = 0;
    initial bad_ops = 0;
    initial last_addr = 8'h00;
    always @(posedge sclk or negedge sel)
    begin
        if (!sel)
        begin
            n = 0;
            // released line shows the inverse of its last value
            dq <= ~dq;
        end
        // start, op and address on rising edges
        else if (n < 11)
        begin
            if (n > 0 || din)
            begin
                sh = {sh[9:0], din};
                n++;
                if (n == 11)
                begin
                    frames++;
                    last_addr = sh[7:0];
                    if (sh[9:8] !== 2'h2)
                        bad_ops++;
                    w = {sh[7:0], ~sh[7:0]};
                    // dummy zero after the last address rise
                    dq <= #(slow ? 100 : 2) 1'h0;
                end
            end
        end
        // word msb first, changing after rising edges
        else if (n < 27)
        begin
            dq <= #(slow ? 100 : 2) w[26-n];
            n++;
        end
    end
endmodule

// ### test/sewr_top_sva.sv
`timescale 1ns/1ns
module sewr_top_sva
    import sewr_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH,
    parameter int WIDTH = WORD_W
)
(
    // system side
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic rd_valid,
    input wire logic rd_ready,
    input wire logic [WIDTH-1:0] rd_data,
    // link side
    input wire logic link_clk,
    input wire logic memory_select_out,
    input wire logic shift_clk_out,
    input wire logic serial_data_line_in,
    input wire logic serial_data_line_out,
    input wire logic serial_data_line_oe_n,
    input wire logic word_size_strap
);
    logic [7:0] oe_cnt_reg;
    logic [7:0] sel_cnt_reg;
    // frame spans are too long for a repetition
    always_ff @(posedge link_clk or posedge rst)
    begin
        if (rst)
        begin
            oe_cnt_reg <= 8'h00;
            sel_cnt_reg <= 8'h00;
        end
        else
        begin
            oe_cnt_reg <= serial_data_line_oe_n ? 8'h00 : oe_cnt_reg + 8'h01;
            sel_cnt_reg <= memory_select_out ? sel_cnt_reg + 8'h01 : 8'h00;
        end
    end
    a_strap_wide: assert property (@(posedge clk) disable iff (rst) word_size_strap)
        else $error("strap not wide");
    a_select_first: assert property (@(posedge link_clk) disable iff (rst) $rose(memory_select_out) |->
        !shift_clk_out ##0 (!serial_data_line_out && !serial_data_line_oe_n)[*8] ##1 serial_data_line_out)
        else $error("start bit not one slot after select");
    a_read_op: assert property (@(posedge link_clk) disable iff (rst) $rose(memory_select_out) |->
        ##16 serial_data_line_out ##8 !serial_data_line_out)
        else $error("op code not read");
    a_out_on_fall: assert property (@(posedge link_clk) disable iff (rst)
        ($changed(serial_data_line_out) && !serial_data_line_oe_n && !$past(serial_data_line_oe_n))
        |-> $fell(shift_clk_out))
        else $error("data changed off a falling edge");
    a_release_line: assert property (@(posedge link_clk) disable iff (rst)
        $rose(serial_data_line_oe_n) |-> oe_cnt_reg == 8'h60)
        else $error("line not released after address");
    a_frame_span: assert property (@(posedge link_clk) disable iff (rst)
        $fell(memory_select_out) |-> sel_cnt_reg == 8'hE8)
        else $error("select span wrong");
    a_idle_gap: assert property (@(posedge link_clk) disable iff (rst)
        $fell(memory_select_out) |-> (!memory_select_out && !shift_clk_out)[*8])
        else $error("no idle slot after frame");
    a_sclk_shape: assert property (@(posedge link_clk) disable iff (rst)
        $rose(shift_clk_out) |-> shift_clk_out[*4] ##1 !shift_clk_out)
        else $error("shift clock shape wrong");
    a_one_request: assert property (@(posedge clk) disable iff (rst)
        (req_valid && req_ready) |=> !req_ready)
        else $error("second request while busy");
    a_word_holds: assert property (@(posedge clk) disable iff (rst)
        (rd_valid && !rd_ready) |=> rd_valid && $stable(rd_data))
        else $error("word lost while stalled");
endmodule
bind sewr_top sewr_top_sva #(.DEPTH(DEPTH), .WIDTH(WIDTH)) u_sva (.clk(clk), .rst(rst), .ce(ce),
    .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .link_clk(link_clk), .memory_select_out(memory_select_out),
    .shift_clk_out(shift_clk_out), .serial_data_line_in(serial_data_line_in),
    .serial_data_line_out(serial_data_line_out), .serial_data_line_oe_n(serial_data_line_oe_n),
    .word_size_strap(word_size_strap));

// ### test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'h0;
    logic link_clk = 1'h0;
    logic rst = 1'h1;
    logic req_valid = 1'h0;
    logic rd_ready = 1'h0;
    logic ce = 1'h1;
    logic slow = 1'h0;
    logic [7:0] req_addr = 8'h00;
    logic req_ready, rd_valid, sel, sclk, dout, oe_n, strap, line, mdq;
    logic [15:0] rd_data;
    logic [7:0] last_addr;
    int frames, bad_ops;
    int n_errors = 0;
    int compares = 0;
    always #5 clk = ~clk;
    initial #7 forever #24 link_clk = ~link_clk;
    // the block wins while it drives; the memory is seen only once the line is released
    assign line = oe_n ? mdq : dout;
    sewr_top dut (.clk(clk), .rst(rst), .ce(ce), .req_valid(req_valid), .req_ready(req_ready),
        .req_addr(req_addr), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .link_clk(link_clk), .memory_select_out(sel), .shift_clk_out(sclk), .serial_data_line_in(line),
        .serial_data_line_out(dout), .serial_data_line_oe_n(oe_n), .word_size_strap(strap));
    sewr_mem_model mem (.sel(sel), .sclk(sclk), .din(line), .slow(slow), .dq(mdq),
        .last_addr(last_addr), .frames(frames), .bad_ops(bad_ops));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic send(input logic [7:0] a);
        int i;
        i = 0;
        @(posedge clk);
        req_valid <= 1'h1;
        req_addr <= a;
        do
            @(negedge clk);
        while (req_ready !== 1'h1 && ++i < 3000);
        chk("req_ready", 16'h0001, {15'h0000, req_ready});
        @(posedge clk);
        req_valid <= 1'h0;
    endtask
    task automatic take(input logic [7:0] a);
        int i;
        i = 0;
        @(negedge clk);
        while (rd_valid !== 1'h1 && i++ < 3000)
            @(negedge clk);
        chk("rd_valid", 16'h0001, {15'h0000, rd_valid});
        chk("rd_data", {a, ~a}, rd_data);
        @(posedge clk);
        rd_ready <= 1'h1;
        @(posedge clk);
        rd_ready <= 1'h0;
    endtask
    task automatic t_reset();
        @(negedge clk);
        chk("select", 16'h0000, {15'h0000, sel});
        chk("oe_n", 16'h0001, {15'h0000, oe_n});
        chk("strap", 16'h0001, {15'h0000, strap});
        chk("rd_valid", 16'h0000, {15'h0000, rd_valid});
    endtask
    task automatic t_single();
        send(8'h00);
        take(8'h00);
        chk("address", 16'h0000, {8'h00, last_addr});
        chk("bad ops", 16'h0000, 16'(bad_ops));
    endtask
    // receiver stalls until both entries fill, then the block must refuse
    task automatic t_fill();
        int i;
        i = 0;
        send(8'hFF);
        send(8'h5A);
        while (frames < 3 && i++ < 3000)
            @(negedge clk);
        // let the third frame finish so that only the full buffer holds ready low
        repeat (1500) @(negedge clk);
        chk("req_ready full", 16'h0000, {15'h0000, req_ready});
        take(8'hFF);
        take(8'h5A);
        chk("address", 16'h005A, {8'h00, last_addr});
    endtask
    task automatic t_slow();
        @(posedge clk);
        slow <= 1'h1;
        send(8'h81);
        take(8'h81);
        slow <= 1'h0;
        chk("frames", 16'h0004, 16'(frames));
    endtask
    // a low enable freezes the buffer: a pop offered then must not happen
    task automatic t_hold();
        int i;
        i = 0;
        send(8'h3C);
        while (rd_valid !== 1'h1 && i++ < 3000)
            @(negedge clk);
        @(posedge clk);
        ce <= 1'h0;
        rd_ready <= 1'h1;
        @(posedge clk);
        rd_ready <= 1'h0;
        @(negedge clk);
        chk("req_ready held", 16'h0000, {15'h0000, req_ready});
        chk("rd_valid held", 16'h0001, {15'h0000, rd_valid});
        @(posedge clk);
        ce <= 1'h1;
        take(8'h3C);
        chk("frames", 16'h0005, 16'(frames));
    endtask
    task automatic results();
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_single();
        t_fill();
        t_slow();
        t_hold();
        results();
    end
    // five frames take about 6000 clocks
    initial
    begin
        #300000;
        n_errors++;
        results();
    end
endmodule
